// ### frame_sync_pkg.sv
// constants shared by the frame-alignment configuration slice
// assumes a 16-bit register port addressed by word offsets, no byte lanes
package frame_sync_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [7:0] OFFS_TICK_MULTIPLIER   = 8'h07;
  localparam logic [7:0] OFFS_THIRD_SLOPE       = 8'h0B;
  localparam logic [7:0] OFFS_ANALOG_GAIN       = 8'h0C;
  localparam logic [7:0] OFFS_DIGITAL_GAIN      = 8'h0D;
  localparam logic [7:0] OFFS_FRAME_UPDATE      = 8'h0E;

  // reset values
  localparam logic [15:0] RESET_TICK_MULTIPLIER = 16'h0001;
  localparam logic [15:0] RESET_THIRD_SLOPE     = 16'h0000;
  localparam logic [15:0] RESET_ANALOG_GAIN     = 16'h01E2;
  localparam logic [15:0] RESET_DIGITAL_GAIN    = 16'h0080;
  localparam logic [15:0] RESET_FRAME_UPDATE    = 16'h033F;

  // implemented bits; everything else reads as zero
  localparam logic [15:0] MASK_ANALOG_GAIN      = 16'h21E3;
  localparam logic [15:0] MASK_DIGITAL_GAIN     = 16'h0FFF;
  localparam logic [15:0] MASK_FRAME_UPDATE     = 16'h073F;

  // analog and digital gain fields
  localparam int FIRST_AMP_LSB  = 0;
  localparam int FIRST_AMP_W    = 2;
  localparam int SECOND_AMP_LSB = 5;
  localparam int SECOND_AMP_W   = 4;
  localparam int GAIN_LAT_COMP_BIT = 13;
  localparam int DIGITAL_MULT_W = 12;

  // frame update control fields
  localparam int READOUT_LENGTH_FRAME_ALIGN_BIT = 0;
  localparam int DARK_ROWS_ALIGN_BIT     = 1;
  localparam int FILLER_ROWS_ALIGN_BIT   = 2;
  localparam int INTEGRATION_ALIGN_BIT   = 3;
  localparam int GAIN_ALIGN_BIT          = 4;
  localparam int REGION_ALIGN_BIT        = 5;
  localparam int BLANK_REGION_SWITCH_BIT = 8;
  localparam int BLANK_SUBSAMPLE_BIT     = 9;
  localparam int INTEGRATION_SYNC_MODE_BIT = 10;

endpackage

// ### frame_aligned_shadow.sv
// one parameter's working copy, taken from the written value
// assumes updateEvent is a one-cycle pulse on core_clk
`timescale 1ns/1ns
module frame_aligned_shadow #(
  parameter int          WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // control
  input  wire logic [WIDTH-1:0] writtenValue,
  input  wire logic             alignEnable,
  input  wire logic             updateEvent,
  // working copy
  output logic      [WIDTH-1:0] appliedValue
);

  typedef struct packed {
    logic [WIDTH-1:0] applied;
  } shadow_state_t;

  shadow_state_t state;
  shadow_state_t next_state;

  always_comb begin
    next_state = state;
    // the written value is the shadow; it moves over only on the event when aligned
    if (!alignEnable || updateEvent) begin
      next_state.applied = writtenValue;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state.applied <= RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  assign appliedValue = state.applied;

endmodule

// ### frame_sync_config_regs.sv
// frame-alignment configuration slice: gain, third-slope time, update timing and blanking
// assumes frame timing pulses and mode levels arrive synchronous to core_clk
//
// Operation
// - third-slope time only counts in global shutter
// - latency compensation delays gain one extra frame
// - without compensation gain applies next frame start
// - bit 0 aligns readout length to frame
// - bit 1 aligns dark row count to frame
// - bit 2 aligns filler row count to frame
// - bit 3 aligns integration and third-slope time to the integration event
// - bit 4 aligns gain settings to frame
// - bit 5 aligns region selection to frame
// - bit 8 blanks frame after region change
// - bit 9 blanks after subsampling change, global
// - rolling shutter always blanks after subsampling change
// - sync mode 0 latches integration at overhead
// - sync mode 1 tracks integration values continuously outside triggered global master
// - triggered global shutter master mode 1 latches at integration start
// - integration unit equals multiplier clock periods, global shutter only
`timescale 1ns/1ns
module frame_sync_config_regs
  import frame_sync_pkg::*;
#(
  parameter int READOUT_LENGTH_W = 8,
  parameter int DARK_ROWS_W      = 8,
  parameter int FILLER_ROWS_W    = 12,
  parameter int INTEGRATION_W    = 16,
  parameter int REGION_W         = 8,
  parameter int SUBSAMPLE_W      = 2
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // register port
  input  wire logic [frame_sync_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [frame_sync_pkg::DATA_W-1:0] regWriteData,
  input  wire logic                            regWrite,
  input  wire logic                            regRead,
  output logic      [frame_sync_pkg::DATA_W-1:0] regReadData,
  // frame timing events
  input  wire logic                            frameStart,
  input  wire logic                            frameOverheadTimeStart,
  input  wire logic                            integrationStart,
  // operating mode
  input  wire logic                            globalShutter,
  input  wire logic                            triggeredMaster,
  input  wire logic [SUBSAMPLE_W-1:0]          subsampleMode,
  // written values held by neighbouring register blocks
  input  wire logic [READOUT_LENGTH_W-1:0]     rollingLineReadoutLengthIn,
  input  wire logic [DARK_ROWS_W-1:0]          darkRowsIn,
  input  wire logic [FILLER_ROWS_W-1:0]        fillerRowsIn,
  input  wire logic [INTEGRATION_W-1:0]        integrationTimeIn,
  input  wire logic [REGION_W-1:0]             regionSelectIn,
  // applied working values
  output logic      [READOUT_LENGTH_W-1:0]     rollingLineReadoutLength,
  output logic      [DARK_ROWS_W-1:0]          darkRows,
  output logic      [FILLER_ROWS_W-1:0]        fillerRows,
  output logic      [INTEGRATION_W-1:0]        integrationTime,
  output logic      [REGION_W-1:0]             regionSelect,
  output logic      [15:0]                     thirdSlopeIntegrationTime,
  // applied gains
  output logic      [frame_sync_pkg::FIRST_AMP_W-1:0]    firstAmplifierSetting,
  output logic      [frame_sync_pkg::SECOND_AMP_W-1:0]   secondAmplifierSetting,
  output logic      [frame_sync_pkg::DIGITAL_MULT_W-1:0] digitalMultiplier,
  // frame control
  output logic                                 blankFrame,
  output logic                                 integrationTick
);

  localparam int GAIN_W = FIRST_AMP_W + SECOND_AMP_W + DIGITAL_MULT_W;

  typedef struct packed {
    logic [15:0]               tickMultiplier;
    logic [15:0]               thirdSlope;
    logic [15:0]               analogGain;
    logic [15:0]               digitalGain;
    logic [15:0]               frameUpdate;
    logic [DATA_W-1:0]         readData;
    logic [GAIN_W-1:0]         gainDelayed;
    logic [GAIN_W-1:0]         gainApplied;
    logic [15:0]               thirdSlopeOut;
    logic [15:0]               tickCount;
    logic                      tick;
    logic                      blankPending;
    logic                      blank;
    logic                      frameStartSeen;
    logic [REGION_W-1:0]       regionPrevious;
    logic [SUBSAMPLE_W-1:0]    subsamplePrevious;
  } regs_state_t;

  localparam regs_state_t STATE_RESET = '{
    tickMultiplier:    RESET_TICK_MULTIPLIER,
    thirdSlope:        RESET_THIRD_SLOPE,
    analogGain:        RESET_ANALOG_GAIN,
    digitalGain:       RESET_DIGITAL_GAIN,
    frameUpdate:       RESET_FRAME_UPDATE,
    readData:          '0,
    gainDelayed:       {RESET_ANALOG_GAIN[FIRST_AMP_LSB +: FIRST_AMP_W],
                        RESET_ANALOG_GAIN[SECOND_AMP_LSB +: SECOND_AMP_W],
                        RESET_DIGITAL_GAIN[DIGITAL_MULT_W-1:0]},
    gainApplied:       {RESET_ANALOG_GAIN[FIRST_AMP_LSB +: FIRST_AMP_W],
                        RESET_ANALOG_GAIN[SECOND_AMP_LSB +: SECOND_AMP_W],
                        RESET_DIGITAL_GAIN[DIGITAL_MULT_W-1:0]},
    thirdSlopeOut:     16'h0000,
    tickCount:         16'h0000,
    tick:              1'b0,
    blankPending:      1'b0,
    blank:             1'b0,
    frameStartSeen:    1'b0,
    regionPrevious:    '0,
    subsamplePrevious: '0
  };

  regs_state_t state;
  regs_state_t next_state;

  // decoded controls
  logic                 integrationEvent;
  logic                 integrationAlign;
  logic [GAIN_W-1:0]    gainWritten;
  logic [15:0]          thirdSlopeApplied;
  logic [15:0]          tickLimit;
  logic                 regionChanged;
  logic                 subsampleChanged;
  logic                 blankRequest;

  // integration settings follow their own event, not the plain frame start
  always_comb begin
    integrationAlign = state.frameUpdate[INTEGRATION_ALIGN_BIT];
    if (!state.frameUpdate[INTEGRATION_SYNC_MODE_BIT]) begin
      integrationEvent = frameOverheadTimeStart;
    end else if (triggeredMaster && globalShutter) begin
      integrationEvent = integrationStart;
    end else begin
      // mode 1 outside triggered global shutter master is unsupported by software; it just tracks
      integrationEvent = 1'b1;
    end
  end

  frame_aligned_shadow #(
    .WIDTH       (READOUT_LENGTH_W),
    .RESET_VALUE ('0)
  ) readoutLengthShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (rollingLineReadoutLengthIn),
    .alignEnable  (state.frameUpdate[READOUT_LENGTH_FRAME_ALIGN_BIT]),
    .updateEvent  (frameStart),
    .appliedValue (rollingLineReadoutLength)
  );

  frame_aligned_shadow #(
    .WIDTH       (DARK_ROWS_W),
    .RESET_VALUE ('0)
  ) darkRowsShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (darkRowsIn),
    .alignEnable  (state.frameUpdate[DARK_ROWS_ALIGN_BIT]),
    .updateEvent  (frameStart),
    .appliedValue (darkRows)
  );

  frame_aligned_shadow #(
    .WIDTH       (FILLER_ROWS_W),
    .RESET_VALUE ('0)
  ) fillerRowsShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (fillerRowsIn),
    .alignEnable  (state.frameUpdate[FILLER_ROWS_ALIGN_BIT]),
    .updateEvent  (frameStart),
    .appliedValue (fillerRows)
  );

  frame_aligned_shadow #(
    .WIDTH       (INTEGRATION_W),
    .RESET_VALUE ('0)
  ) integrationShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (integrationTimeIn),
    .alignEnable  (integrationAlign),
    .updateEvent  (integrationEvent),
    .appliedValue (integrationTime)
  );

  frame_aligned_shadow #(
    .WIDTH       (16),
    .RESET_VALUE (RESET_THIRD_SLOPE)
  ) thirdSlopeShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (state.thirdSlope),
    .alignEnable  (integrationAlign),
    .updateEvent  (integrationEvent),
    .appliedValue (thirdSlopeApplied)
  );

  frame_aligned_shadow #(
    .WIDTH       (REGION_W),
    .RESET_VALUE ('0)
  ) regionShadow (
    .core_clk     (core_clk),
    .reset        (reset),
    .writtenValue (regionSelectIn),
    .alignEnable  (state.frameUpdate[REGION_ALIGN_BIT]),
    .updateEvent  (frameStart),
    .appliedValue (regionSelect)
  );

  assign gainWritten = {state.analogGain[FIRST_AMP_LSB +: FIRST_AMP_W],
                        state.analogGain[SECOND_AMP_LSB +: SECOND_AMP_W],
                        state.digitalGain[DIGITAL_MULT_W-1:0]};

  // a zero multiplier would stall the tick, so it behaves as one
  assign tickLimit = (state.tickMultiplier == 16'h0000) ? 16'h0000 : state.tickMultiplier - 16'h0001;

  // changes are seen in the same cycle the working copy moves
  assign regionChanged    = (regionSelect != state.regionPrevious);
  assign subsampleChanged = (subsampleMode != state.subsamplePrevious);
  assign blankRequest     = (regionChanged && state.frameUpdate[BLANK_REGION_SWITCH_BIT])
                          || (subsampleChanged && globalShutter
                              && state.frameUpdate[BLANK_SUBSAMPLE_BIT])
                          || (subsampleChanged && !globalShutter);

  always_comb begin
    next_state = state;

    // register writes; unimplemented bits are dropped so they read as zero
    if (regWrite) begin
      unique case (regAddr)
        OFFS_TICK_MULTIPLIER: begin
          next_state.tickMultiplier = regWriteData;
        end
        OFFS_THIRD_SLOPE: begin
          next_state.thirdSlope = regWriteData;
        end
        OFFS_ANALOG_GAIN: begin
          next_state.analogGain = regWriteData & MASK_ANALOG_GAIN;
        end
        OFFS_DIGITAL_GAIN: begin
          next_state.digitalGain = regWriteData & MASK_DIGITAL_GAIN;
        end
        OFFS_FRAME_UPDATE: begin
          next_state.frameUpdate = regWriteData & MASK_FRAME_UPDATE;
        end
        default: begin
        end
      endcase
    end

    // reads show the programmed value, never the applied one
    next_state.readData = '0;
    if (regRead) begin
      unique case (regAddr)
        OFFS_TICK_MULTIPLIER: begin
          next_state.readData = state.tickMultiplier;
        end
        OFFS_THIRD_SLOPE: begin
          next_state.readData = state.thirdSlope;
        end
        OFFS_ANALOG_GAIN: begin
          next_state.readData = state.analogGain;
        end
        OFFS_DIGITAL_GAIN: begin
          next_state.readData = state.digitalGain;
        end
        OFFS_FRAME_UPDATE: begin
          next_state.readData = state.frameUpdate;
        end
        default: begin
          next_state.readData = '0;
        end
      endcase
    end

    // gain update timing
    if (!state.frameUpdate[GAIN_ALIGN_BIT]) begin
      // unaligned gains also bypass the latency compensation
      next_state.gainApplied = gainWritten;
      next_state.gainDelayed = gainWritten;
    end else if (frameStart) begin
      next_state.gainDelayed = gainWritten;
      if (state.analogGain[GAIN_LAT_COMP_BIT]) begin
        next_state.gainApplied = state.gainDelayed;
      end else begin
        next_state.gainApplied = gainWritten;
      end
    end

    // third-slope time only reaches the sequencer in global shutter
    next_state.thirdSlopeOut = globalShutter ? thirdSlopeApplied : 16'h0000;

    // integration time base
    next_state.tick = 1'b0;
    if (!globalShutter) begin
      next_state.tickCount = 16'h0000;
    end else if (state.tickCount >= tickLimit) begin
      next_state.tickCount = 16'h0000;
      next_state.tick      = 1'b1;
    end else begin
      next_state.tickCount = state.tickCount + 16'h0001;
    end

    // blanking of the first frame after a switch
    next_state.regionPrevious    = regionSelect;
    next_state.subsamplePrevious = subsampleMode;
    next_state.frameStartSeen    = frameStart;
    if (frameStart) begin
      next_state.blank        = state.blankPending;
      next_state.blankPending = 1'b0;
    end
    if (blankRequest) begin
      // a change caught at or right after a frame start belongs to that frame
      if (state.frameStartSeen || frameStart) begin
        next_state.blank = 1'b1;
      end else begin
        next_state.blankPending = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign regReadData               = state.readData;
  assign thirdSlopeIntegrationTime = state.thirdSlopeOut;
  assign firstAmplifierSetting     = state.gainApplied[GAIN_W-1 -: FIRST_AMP_W];
  assign secondAmplifierSetting    = state.gainApplied[DIGITAL_MULT_W +: SECOND_AMP_W];
  assign digitalMultiplier         = state.gainApplied[DIGITAL_MULT_W-1:0];
  assign blankFrame                = state.blank;
  assign integrationTick           = state.tick;

endmodule

// ### frame_sync_config_regs_checker.sv
// concurrent checks on the frame-alignment configuration slice
// assumes it is bound to frame_sync_config_regs and sees only its ports
`timescale 1ns/1ns
module frame_sync_config_regs_checker
  import frame_sync_pkg::*;
#(
  parameter int READOUT_LENGTH_W = 8,
  parameter int DARK_ROWS_W      = 8,
  parameter int FILLER_ROWS_W    = 12,
  parameter int REGION_W         = 8
) (
  // clock and reset
  input wire logic                                      core_clk,
  input wire logic                                      reset,
  // register port
  input wire logic [frame_sync_pkg::ADDR_W-1:0]         regAddr,
  input wire logic [frame_sync_pkg::DATA_W-1:0]         regWriteData,
  input wire logic                                      regWrite,
  input wire logic                                      regRead,
  input wire logic [frame_sync_pkg::DATA_W-1:0]         regReadData,
  // timing and mode
  input wire logic                                      frameStart,
  input wire logic                                      globalShutter,
  // written and applied values
  input wire logic [READOUT_LENGTH_W-1:0]               rollingLineReadoutLengthIn,
  input wire logic [FILLER_ROWS_W-1:0]                  fillerRowsIn,
  input wire logic [READOUT_LENGTH_W-1:0]               rollingLineReadoutLength,
  input wire logic [DARK_ROWS_W-1:0]                    darkRows,
  input wire logic [FILLER_ROWS_W-1:0]                  fillerRows,
  input wire logic [REGION_W-1:0]                       regionSelect,
  input wire logic [15:0]                               thirdSlopeIntegrationTime,
  input wire logic [frame_sync_pkg::DIGITAL_MULT_W-1:0] digitalMultiplier,
  input wire logic                                      blankFrame,
  input wire logic                                      integrationTick
);
  logic [15:0] fuReg;

  // mirror of the update control register, kept from the write strobes alone
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fuReg <= RESET_FRAME_UPDATE;
    end else if (regWrite && regAddr == OFFS_FRAME_UPDATE) begin
      fuReg <= regWriteData & MASK_FRAME_UPDATE;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_read_idle: assert property (!$past(regRead) |-> regReadData == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  chk_fu_readback: assert property (regWrite && regAddr == OFFS_FRAME_UPDATE ##1 regRead &&
    regAddr == OFFS_FRAME_UPDATE |=> regReadData == ($past(regWriteData, 2) & MASK_FRAME_UPDATE))
    else $error("update control readback differs from written value");
  chk_slope_rolling: assert property (!globalShutter && !$past(globalShutter) && !$past(globalShutter, 2)
    |-> thirdSlopeIntegrationTime == 16'h0000) else $error("third slope time nonzero in rolling shutter");
  chk_tick_rolling: assert property (!globalShutter && !$past(globalShutter) && !$past(globalShutter, 2)
    |-> !integrationTick) else $error("integration tick in rolling shutter");
  chk_readout_free: assert property (!$past(fuReg[0]) |->
    rollingLineReadoutLength == $past(rollingLineReadoutLengthIn)) else $error("readout length not tracking");
  chk_dark_align: assert property ($past(fuReg[1]) && !$past(frameStart) |-> $stable(darkRows))
    else $error("dark rows changed away from frame start");
  chk_filler_free: assert property (!$past(fuReg[2]) |-> fillerRows == $past(fillerRowsIn))
    else $error("filler rows not tracking");
  chk_region_align: assert property ($past(fuReg[5]) && !$past(frameStart) |-> $stable(regionSelect))
    else $error("region changed away from frame start");
  chk_gain_align: assert property ($past(fuReg[4]) && !$past(frameStart) |-> $stable(digitalMultiplier))
    else $error("digital gain changed away from frame start");
  chk_blank_edge: assert property ($changed(blankFrame) |->
    $past(frameStart) || $past(frameStart, 2) || $past(frameStart, 3)) else $error("blank changed mid-frame");

  cover property (blankFrame);
  cover property (integrationTick);
  cover property (regRead ##1 regReadData != 16'h0000);
endmodule

bind frame_sync_config_regs frame_sync_config_regs_checker #(.READOUT_LENGTH_W(READOUT_LENGTH_W),
  .DARK_ROWS_W(DARK_ROWS_W), .FILLER_ROWS_W(FILLER_ROWS_W), .REGION_W(REGION_W)) i_frame_sync_config_regs_checker (.*);

// ### frame_sync_host.sv
// host model driving the register port of the configuration slice
// assumes every task is entered just after a rising edge of core_clk
`timescale 1ns/1ns
module frame_sync_host
  import frame_sync_pkg::*;
(
  // clock
  input wire logic                              core_clk,
  // register port
  output logic      [frame_sync_pkg::ADDR_W-1:0] regAddr,
  output logic      [frame_sync_pkg::DATA_W-1:0] regWriteData,
  output logic                                  regWrite,
  output logic                                  regRead,
  input wire logic  [frame_sync_pkg::DATA_W-1:0] regReadData,
  // set only while running triggered global master
  input wire logic                              syncModeAllowed
);
  initial begin
    regAddr = 8'h00;
    regWriteData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == OFFS_FRAME_UPDATE && !syncModeAllowed) begin
      v[INTEGRATION_SYNC_MODE_BIT] = 1'b0;
    end
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge core_clk);
    regWrite <= 1'b0;
    // idle data inverted so a stale sample cannot pass; address left for a read at once
    regWriteData <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge core_clk);
    d = regReadData;
    @(posedge core_clk);
  endtask
endmodule

// ### frame_sync_config_regs_tb.sv
// self-checking bench for the frame-alignment configuration slice
// assumes frame_sync_host as the register master and the bound checker
`timescale 1ns/1ns
module frame_sync_config_regs_tb;
  import frame_sync_pkg::*;
  logic        core_clk, reset, regWrite, regRead, frameStart, frameOverheadTimeStart, integrationStart;
  logic        globalShutter, triggeredMaster, syncModeAllowed, blankFrame, integrationTick;
  logic [7:0]  regAddr, rollingLineReadoutLengthIn, darkRowsIn, regionSelectIn;
  logic [7:0]  rollingLineReadoutLength, darkRows, regionSelect;
  logic [15:0] regWriteData, regReadData, integrationTimeIn, integrationTime, thirdSlopeIntegrationTime;
  logic [11:0] fillerRowsIn, fillerRows, digitalMultiplier;
  logic [1:0]  subsampleMode, firstAmplifierSetting;
  logic [3:0]  secondAmplifierSetting;
  int          error_cnt, checks;

  frame_sync_config_regs i_frame_sync_config_regs (.*);
  frame_sync_host i_frame_sync_host (.*);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    i_frame_sync_host.wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    @(posedge core_clk);
    i_frame_sync_host.rd(a, d);
    chk("readback", d, exp);
  endtask

  // kind 0 frame start, 1 overhead start, 2 integration start; ends mid-cycle, settled
  task automatic pulse(input int kind);
    @(posedge core_clk);
    frameStart <= (kind == 0);
    frameOverheadTimeStart <= (kind == 1);
    integrationStart <= (kind == 2);
    @(posedge core_clk);
    frameStart <= 1'b0;
    frameOverheadTimeStart <= 1'b0;
    integrationStart <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic t_reset();
    chk("first amp", firstAmplifierSetting, 2'h2);
    chk("second amp", secondAmplifierSetting, 4'hF);
    rd(OFFS_TICK_MULTIPLIER, RESET_TICK_MULTIPLIER);
    rd(OFFS_THIRD_SLOPE, RESET_THIRD_SLOPE);
    rd(OFFS_ANALOG_GAIN, RESET_ANALOG_GAIN);
    rd(OFFS_DIGITAL_GAIN, RESET_DIGITAL_GAIN);
    rd(OFFS_FRAME_UPDATE, RESET_FRAME_UPDATE);
    rd(8'h20, 16'h0000);
    wr(OFFS_DIGITAL_GAIN, 16'hFFFF);
    rd(OFFS_DIGITAL_GAIN, 16'h0FFF);
    wr(OFFS_ANALOG_GAIN, 16'hFFFF);
    rd(OFFS_ANALOG_GAIN, 16'h21E3);
    wr(OFFS_ANALOG_GAIN, 16'h01E2);
    wr(OFFS_DIGITAL_GAIN, 16'h0080);
  endtask

  task automatic t_gain();
    wr(OFFS_DIGITAL_GAIN, 16'h0123);
    pulse(1);
    chk("gain held", digitalMultiplier, 12'h080);
    pulse(0);
    chk("gain at frame", digitalMultiplier, 12'h123);
    wr(OFFS_ANALOG_GAIN, 16'h21E2);
    wr(OFFS_DIGITAL_GAIN, 16'h0055);
    pulse(0);
    chk("gain postponed", digitalMultiplier, 12'h123);
    pulse(0);
    chk("gain late", digitalMultiplier, 12'h055);
    wr(OFFS_FRAME_UPDATE, 16'h032F);
    wr(OFFS_DIGITAL_GAIN, 16'h0777);
    pulse(2);
    chk("gain free", digitalMultiplier, 12'h777);
    wr(OFFS_FRAME_UPDATE, 16'h033F);
  endtask

  task automatic t_sync();
    logic [15:0] d;
    syncModeAllowed = 1'b1;
    globalShutter <= 1'b1;
    triggeredMaster <= 1'b1;
    @(posedge core_clk);
    i_frame_sync_host.wr(OFFS_FRAME_UPDATE, 16'hFFFF);
    i_frame_sync_host.rd(OFFS_FRAME_UPDATE, d);
    chk("sync readback", d, 16'h073F);
    integrationTimeIn <= 16'h1111;
    pulse(1);
    chk("integ at overhead", integrationTime, 16'h0000);
    pulse(2);
    chk("integ at start", integrationTime, 16'h1111);
    wr(OFFS_FRAME_UPDATE, 16'h033F);
    triggeredMaster <= 1'b0;
    syncModeAllowed = 1'b0;
  endtask

  task automatic t_tick_slope();
    int n;
    wr(OFFS_TICK_MULTIPLIER, 16'h0003);
    wr(OFFS_THIRD_SLOPE, 16'h1234);
    n = 0;
    while (integrationTick !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (integrationTick !== 1'b1 && n < 20);
    chk("tick spacing", n, 3);
    pulse(1);
    chk("slope global", thirdSlopeIntegrationTime, 16'h1234);
    @(posedge core_clk);
    globalShutter <= 1'b0;
    pulse(2);
    chk("slope rolling", thirdSlopeIntegrationTime, 16'h0000);
  endtask

  task automatic t_align();
    @(posedge core_clk);
    rollingLineReadoutLengthIn <= 8'hA5;
    darkRowsIn <= 8'h3C;
    fillerRowsIn <= 12'hABC;
    integrationTimeIn <= 16'h0F0F;
    regionSelectIn <= 8'h5A;
    pulse(2);
    chk("readout held", rollingLineReadoutLength, 8'h00);
    chk("filler held", fillerRows, 12'h000);
    pulse(0);
    chk("readout framed", rollingLineReadoutLength, 8'hA5);
    chk("dark framed", darkRows, 8'h3C);
    chk("filler framed", fillerRows, 12'hABC);
    chk("region framed", regionSelect, 8'h5A);
    chk("integ not at frame", integrationTime, 16'h1111);
    pulse(1);
    chk("integ at overhead", integrationTime, 16'h0F0F);
    wr(OFFS_FRAME_UPDATE, 16'h0300);
    darkRowsIn <= 8'hC3;
    integrationTimeIn <= 16'hF0F0;
    regionSelectIn <= 8'hA5;
    pulse(2);
    chk("dark free", darkRows, 8'hC3);
    chk("integ free", integrationTime, 16'hF0F0);
    chk("region free", regionSelect, 8'hA5);
  endtask

  task automatic t_blank();
    pulse(0);
    pulse(0);
    chk("blank cleared", blankFrame, 1'b0);
    @(posedge core_clk);
    subsampleMode <= 2'h1;
    pulse(0);
    chk("blank rolling", blankFrame, 1'b1);
    wr(OFFS_FRAME_UPDATE, 16'h0100);
    globalShutter <= 1'b1;
    pulse(0);
    @(posedge core_clk);
    subsampleMode <= 2'h2;
    pulse(0);
    chk("no blank global", blankFrame, 1'b0);
    @(posedge core_clk);
    regionSelectIn <= 8'h11;
    pulse(0);
    chk("blank region", blankFrame, 1'b1);
    wr(OFFS_FRAME_UPDATE, 16'h0200);
    subsampleMode <= 2'h3;
    pulse(0);
    chk("blank subsample global", blankFrame, 1'b1);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    reset = 1'b1;
    {frameStart, frameOverheadTimeStart, integrationStart, globalShutter, triggeredMaster} = 5'h00;
    syncModeAllowed = 1'b0;
    subsampleMode = 2'h0;
    {rollingLineReadoutLengthIn, darkRowsIn, regionSelectIn} = 24'h000000;
    fillerRowsIn = 12'h000;
    integrationTimeIn = 16'h0000;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_gain();
    t_sync();
    t_tick_slope();
    t_align();
    t_blank();
    print_verdict();
  end
endmodule
